//--- hdl/rsc_regs.vh
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
// Register byte offsets
`define RSC_CAUSE_OFF 12'h000
`define RSC_CTRL_OFF 12'h004
`define RSC_PERIPH_OFF 12'h008
`define RSC_STATUS_OFF 12'h00C
// Cause record bit positions
`define RSC_CAUSE_EXT 0
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_BOR 2
`define RSC_CAUSE_WDT 3
`define RSC_CAUSE_SW 4
// Control bit positions
`define RSC_CTRL_BOR_EN 1
`define RSC_CTRL_SYSREQ 2
// Status bit positions
`define RSC_STAT_BOR_IRQ 0
`define RSC_STAT_STRAP 1
// Reset values
`define RSC_CTRL_RST 32'h00000000
`define RSC_PERIPH_RST 32'h00000000
`define RSC_CAUSE_RST 5'h02
// Synchroniser depth for reset release
`define RSC_SYNC_STAGES 2
`endif

//--- hdl/rsc_reset_source_control.v
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Hazards and limits
// Pin, brown-out and watchdog reset core and peripherals asynchronously, a system request from the next clock edge; release is
// always two clock edges through a synchroniser plus one output flop.
// The core request input is a level; holding it high restarts the reset each
// time the previous one ends.
// A peripheral pulse is lost if a system reset lands between the one and the zero.
// The test access port sees only the power-on chain; no other source touches it.
`include "rsc_regs.vh"

module rsc_reset_source_control #(
    parameter NPERIPH = 16
) (
    input wire pclk,
    input wire presetn,
    input wire por_detect,
    input wire ext_reset_n,
    input wire brownout_detect,
    input wire wdt_reset_req,
    input wire system_reset_request_bit,
    input wire test_mode_strap_0,
    input wire test_mode_strap_1,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg core_reset_n,
    output reg tap_reset_n,
    output reg [NPERIPH-1:0] periph_reset_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Constants and widths

    // Reset images widened once so single bits can be picked out of them
    localparam [31:0] CTRL_RST = `RSC_CTRL_RST;
    localparam [31:0] PERIPH_RST = `RSC_PERIPH_RST;
    localparam [4:0] CAUSE_RST = `RSC_CAUSE_RST;
    // Number of cause bits, one per source
    localparam NCAUSE = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources and routing

    // Power-on, pin, brown-out and watchdog sources assert asynchronously; the system request asserts from its register
    wire sys_src;
    reg bor_en_r;
    reg sysreq_r;
    assign sys_src = !ext_reset_n || (brownout_detect && bor_en_r) || wdt_reset_req
                     || sysreq_r;

    // Power-on chain: clears everything but the APB answer flops, including test access port
    reg [`RSC_SYNC_STAGES-1:0] por_sync_r;
    always @(posedge pclk or posedge por_detect) begin
        if (por_detect) begin
            por_sync_r <= {`RSC_SYNC_STAGES{1'b0}};
        end else begin
            por_sync_r <= {por_sync_r[`RSC_SYNC_STAGES-2:0], 1'b1};
        end
    end
    wire por_n = por_sync_r[`RSC_SYNC_STAGES-1];

    // System chain: por or any system source
    wire sys_async = por_detect || sys_src;
    reg [`RSC_SYNC_STAGES-1:0] sys_sync_r;
    always @(posedge pclk or posedge sys_async) begin
        if (sys_async) begin
            sys_sync_r <= {`RSC_SYNC_STAGES{1'b0}};
        end else begin
            sys_sync_r <= {sys_sync_r[`RSC_SYNC_STAGES-2:0], 1'b1};
        end
    end
    wire sys_n = sys_sync_r[`RSC_SYNC_STAGES-1];

    // Registered reset outputs, released together on one edge
    reg [NPERIPH-1:0] periph_ctl_r;
    reg [NPERIPH-1:0] periph_prev_r;
    reg [NPERIPH-1:0] periph_pulse_r;
    always @(posedge pclk or negedge sys_n) begin
        if (!sys_n) begin
            core_reset_n <= 1'b0;
            periph_reset_n <= {NPERIPH{1'b0}};
        end else begin
            core_reset_n <= 1'b1;
            periph_reset_n <= ~periph_pulse_r;
        end
    end

    // Test access port follows power-on only
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            tap_reset_n <= 1'b0;
        end else begin
            tap_reset_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral software reset: set then clear gives one pulse

    genvar gi;
    generate
        for (gi = 0; gi < NPERIPH; gi = gi + 1) begin : g_per
            always @(posedge pclk or negedge sys_n) begin
                if (!sys_n) begin
                    periph_prev_r[gi] <= 1'b0;
                    periph_pulse_r[gi] <= 1'b0;
                end else begin
                    periph_prev_r[gi] <= periph_ctl_r[gi];
                    periph_pulse_r[gi] <= periph_prev_r[gi] && !periph_ctl_r[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Cause record, survives system resets; only power-on or a write-one-to-clear clears it

    reg [4:0] cause_r;
    reg ext_seen_r;
    reg bor_seen_r;
    reg wdt_seen_r;
    reg sw_seen_r;
    reg bor_irq_r;
    reg clr_cause;
    reg [4:0] clr_mask;
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            cause_r <= CAUSE_RST;
            ext_seen_r <= 1'b0;
            bor_seen_r <= 1'b0;
            wdt_seen_r <= 1'b0;
            sw_seen_r <= 1'b0;
        end else begin
            // Latch which sources were active during the reset, report on release
            ext_seen_r <= !sys_n && (ext_seen_r || !ext_reset_n);
            bor_seen_r <= !sys_n && (bor_seen_r || (brownout_detect && bor_en_r));
            wdt_seen_r <= !sys_n && (wdt_seen_r || wdt_reset_req);
            sw_seen_r <= !sys_n && (sw_seen_r || sysreq_r);
            // Set wins over a software clear in the same cycle
            cause_r <= (cause_r & ~(clr_cause ? clr_mask : 5'h00))
                       | (sys_n ? {sw_seen_r, wdt_seen_r, bor_seen_r, 1'b0, ext_seen_r}
                          : 5'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, unmapped addresses give pslverr

    // Read data is fetched in the first access cycle; a write lands only at the
    // edge where pready is seen high, so it completes together with the transfer
    wire acc = psel && penable && !pready;
    wire done = psel && penable && pready;
    wire wr = done && pwrite;

    // One-hot register selects from the offset
    reg hit_cause;
    reg hit_ctrl;
    reg hit_periph;
    reg hit_status;
    always @* begin
        hit_cause = 1'b0;
        hit_ctrl = 1'b0;
        hit_periph = 1'b0;
        hit_status = 1'b0;
        if (paddr == `RSC_CAUSE_OFF) begin
            hit_cause = 1'b1;
        end else if (paddr == `RSC_CTRL_OFF) begin
            hit_ctrl = 1'b1;
        end else if (paddr == `RSC_PERIPH_OFF) begin
            hit_periph = 1'b1;
        end else if (paddr == `RSC_STATUS_OFF) begin
            hit_status = 1'b1;
        end
    end

    // Write-one-to-clear of the cause record
    always @* begin
        clr_cause = wr && hit_cause;
        clr_mask = pwdata[4:0];
    end

    // Brown-out enable and interrupt flag live in the power-on domain so a system reset keeps them
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            bor_en_r <= CTRL_RST[`RSC_CTRL_BOR_EN];
            bor_irq_r <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                bor_en_r <= pwdata[`RSC_CTRL_BOR_EN];
            end
            // Brown-out event without reset enable: sticky, write one to clear
            if (brownout_detect && !bor_en_r) begin
                bor_irq_r <= 1'b1;
            end else if (wr && hit_status && pwdata[`RSC_STAT_BOR_IRQ]) begin
                bor_irq_r <= 1'b0;
            end
        end
    end

    // System request stays up until the reset it starts has been sampled once,
    // so the cause record can see it; a request during the reset is ignored
    reg sysreq_nxt;
    always @* begin
        sysreq_nxt = sysreq_r;
        if (!sys_n) begin
            sysreq_nxt = 1'b0;
        end else if (system_reset_request_bit
                     || (wr && hit_ctrl && pwdata[`RSC_CTRL_SYSREQ])) begin
            sysreq_nxt = 1'b1;
        end
    end
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            sysreq_r <= 1'b0;
        end else begin
            sysreq_r <= sysreq_nxt;
        end
    end

    // Peripheral reset selects, cleared by every system reset
    always @(posedge pclk or negedge sys_n) begin
        if (!sys_n) begin
            periph_ctl_r <= PERIPH_RST[NPERIPH-1:0];
        end else if (wr && hit_periph) begin
            periph_ctl_r <= pwdata[NPERIPH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer

    // Read data mux; unmapped offsets answer with an error and change nothing
    reg [31:0] prdata_nxt;
    reg pslverr_nxt;
    reg pready_nxt;
    always @* begin
        pready_nxt = acc;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h00000000;
        if (acc) begin
            if (hit_cause) begin
                prdata_nxt[NCAUSE-1:0] = cause_r;
            end else if (hit_ctrl) begin
                prdata_nxt[`RSC_CTRL_BOR_EN] = bor_en_r;
                prdata_nxt[`RSC_CTRL_SYSREQ] = sysreq_r;
            end else if (hit_periph) begin
                prdata_nxt[NPERIPH-1:0] = periph_ctl_r;
            end else if (hit_status) begin
                prdata_nxt[`RSC_STAT_BOR_IRQ] = bor_irq_r;
                prdata_nxt[`RSC_STAT_STRAP] = test_mode_strap_0;
                prdata_nxt[`RSC_STAT_STRAP + 1] = test_mode_strap_1;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // Answer flops: pready, prdata and pslverr stand for one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata <= prdata_nxt;
        end
    end

endmodule

//--- test/reset_source_control_bench.sv
`timescale 1ns/1ns
`include "rsc_regs.vh"
module reset_source_control_bench;
    localparam NP = 16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_reset_n, tap_reset_n, err;
    logic por_detect, ext_reset_n, brownout_detect, wdt_reset_req, sysreq, st0, st1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NP-1:0] periph_reset_n;
    int n_errors = 0, check_count = 0, cyc = 0, exp_cause, sel = 0, lo, bad;
    int bitq[$] = '{`RSC_CAUSE_EXT, `RSC_CAUSE_WDT, `RSC_CAUSE_BOR, `RSC_CAUSE_SW};
    rsc_far_side far (.pclk(pclk), .por_detect(por_detect), .ext_reset_n(ext_reset_n),
        .brownout_detect(brownout_detect), .wdt_reset_req(wdt_reset_req),
        .system_reset_request_bit(sysreq), .test_mode_strap_0(st0), .test_mode_strap_1(st1));
    rsc_reset_source_control #(.NPERIPH(NP)) uut (.pclk(pclk), .presetn(presetn),
        .por_detect(por_detect), .ext_reset_n(ext_reset_n), .brownout_detect(brownout_detect),
        .wdt_reset_req(wdt_reset_req), .system_reset_request_bit(sysreq),
        .test_mode_strap_0(st0), .test_mode_strap_1(st1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_reset_n(core_reset_n), .tap_reset_n(tap_reset_n),
        .periph_reset_n(periph_reset_n));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Cycle ceiling, a count of low cycles on the selected peripheral reset, and of resets seen elsewhere
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (periph_reset_n[sel] === 1'b0) lo <= lo + 1;
        if ((periph_reset_n | (NP'(1) << sel)) !== '1 || core_reset_n !== 1'b1) bad <= bad + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wrel();
        do @(posedge pclk); while (core_reset_n !== 1'b1);
        repeat (2) @(posedge pclk);
    endtask
    task test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rd = $urandom(32'h52780a54);
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wrel();
        apb(0, `RSC_CAUSE_OFF, 0); chk("cause", rd, 32'h2);
        apb(0, `RSC_CTRL_OFF, 0); chk("ctrl", rd, `RSC_CTRL_RST);
        apb(0, `RSC_PERIPH_OFF, 0); chk("periph", rd, `RSC_PERIPH_RST);
        apb(0, `RSC_STATUS_OFF, 0); chk("straps", rd & 32'h6, 0);
        apb(0, 12'h010, 0); chk("slverr", err, 1);
        apb(1, `RSC_CAUSE_OFF, 32'h1F);
        exp_cause = 0;
        foreach (bitq[i]) begin
            apb(1, `RSC_CTRL_OFF, 32'h2);
            far.hold(i, 2 + $urandom % 8);
            wrel();
            exp_cause |= 1 << bitq[i];
            apb(0, `RSC_CAUSE_OFF, 0); chk("cause", rd, exp_cause);
        end
        apb(1, `RSC_CAUSE_OFF, 32'h1F);
        apb(1, `RSC_CTRL_OFF, 32'h0);
        far.hold(2, 6);
        chk("core", core_reset_n, 1);
        apb(0, `RSC_STATUS_OFF, 0); chk("event", rd[0], 1);
        apb(1, `RSC_CTRL_OFF, 32'h4);
        wrel();
        apb(0, `RSC_CAUSE_OFF, 0); chk("cause", rd, 32'h10);
        sel = $urandom % NP;
        {lo, bad} = '0;
        apb(1, `RSC_PERIPH_OFF, 1 << sel);
        apb(1, `RSC_PERIPH_OFF, 0);
        repeat (6) @(posedge pclk);
        chk("pulse", lo, 1);
        chk("others", bad, 0);
        test_done();
    end
endmodule

//--- test/rsc_far_side.sv
`timescale 1ns/1ns
module rsc_far_side #(parameter T_MIN = 4) (
    input wire pclk,
    output reg por_detect, output reg ext_reset_n, output reg brownout_detect,
    output reg wdt_reset_req, output reg system_reset_request_bit,
    output reg test_mode_strap_0, output reg test_mode_strap_1
);
    // Supply rises once; the detector never comes back
    initial begin
        {ext_reset_n, brownout_detect, wdt_reset_req, system_reset_request_bit} = 4'h8;
        {test_mode_strap_0, test_mode_strap_1} = 2'h0;
        por_detect = 1'b1;
        repeat (30) @(posedge pclk);
        por_detect <= 1'b0;
    end
    // Holds one source; the pin never shorter than its minimum
    task hold(input int src, input int n);
        @(posedge pclk);
        case (src)
            0: ext_reset_n <= 1'b0;
            1: wdt_reset_req <= 1'b1;
            2: brownout_detect <= 1'b1;
            default: system_reset_request_bit <= 1'b1;
        endcase
        repeat ((n < T_MIN) ? T_MIN : n) @(posedge pclk);
        {ext_reset_n, brownout_detect, wdt_reset_req, system_reset_request_bit} <= 4'h8;
    endtask
endmodule

//--- test/rsc_reset_source_control_sva.sv
`timescale 1ns/1ns
module rsc_checker #(parameter NPERIPH = 16) (
    input wire pclk, input wire presetn, input wire por_detect, input wire ext_reset_n,
    input wire wdt_reset_req, input wire system_reset_request_bit, input wire core_reset_n,
    input wire tap_reset_n, input wire [NPERIPH-1:0] periph_reset_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Steps of a reset: the port comes free, the request bites
    sequence tap_up_s; ##[0:3] tap_reset_n; endsequence
    sequence core_down_s; ##[0:2] !core_reset_n; endsequence
    tap_por_a: assert property (por_detect |-> !tap_reset_n && !core_reset_n)
        else $error("core or port free during power-on");
    tap_pin_a: assert property (tap_reset_n && !por_detect |=> tap_reset_n)
        else $error("port reset outside power-on");
    core_pin_a: assert property (!ext_reset_n |-> !core_reset_n && periph_reset_n == '0)
        else $error("pin did not reset core and peripherals");
    core_wdt_a: assert property (wdt_reset_req |-> !core_reset_n && periph_reset_n == '0)
        else $error("watchdog did not reset core and peripherals");
    tap_rel_a: assert property ($fell(por_detect) |-> tap_up_s)
        else $error("port not released after power-on");
    core_rel_a: assert property ($rose(core_reset_n) |-> &periph_reset_n)
        else $error("core and peripherals left reset apart");
    rel_src_a: assert property ($rose(core_reset_n) |-> $past(ext_reset_n, 2)
        && !$past(wdt_reset_req, 2) && !$past(por_detect, 2)) else $error("early release");
    sys_req_a: assert property ($rose(system_reset_request_bit) |-> core_down_s)
        else $error("request bit did not reset core");
endmodule
bind rsc_reset_source_control rsc_checker #(.NPERIPH(NPERIPH)) chk_i (.pclk(pclk),
    .presetn(presetn), .por_detect(por_detect), .ext_reset_n(ext_reset_n),
    .wdt_reset_req(wdt_reset_req), .system_reset_request_bit(system_reset_request_bit),
    .core_reset_n(core_reset_n), .tap_reset_n(tap_reset_n), .periph_reset_n(periph_reset_n));
